// ==== hw/tscm_master.sv ====
// Two-wire serial control master: one command at a time from the CPU.
// Assumes open-drain pins with pull-ups and one clock, ref_clk_i.
//
// What this block does
// - SCL generated at up to 400 kHz
// - Standard or fast rate chosen per command
// - Read, write, read-write and write-read transfers
// - Sole master, no arbitration logic
// - No wait states, clock stretching ignored
// - Transfers start only on CPU command
module tscm_master (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire tscm_pkg::tscm_cmd_s cmd_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_take_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output tscm_pkg::tscm_stat_s stat_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_ADDR, ST_WBYTE, ST_RBYTE, ST_RESTART, ST_STOP
  } tscm_state_e;

  tscm_state_e state;
  tscm_pkg::tscm_cmd_s cmd;
  logic phase2;
  logic [tscm_pkg::QTR_W-1:0] qcnt;
  logic [1:0] quarter;
  logic [3:0] bitn;
  logic [8:0] shreg;
  logic [tscm_pkg::LEN_W-1:0] left;
  logic [2:0] sda_sync;
  logic sda_s;
  logic tick;
  logic phase_rd;
  logic scl_low;
  logic sda_low;

  // Clock stretching is not honoured, so scl_i is left unread
  function automatic logic phase_is_read(tscm_pkg::tscm_xfer_e x, logic p2);
    unique case (x)
      tscm_pkg::XFER_READ: phase_is_read = 1'b1;
      tscm_pkg::XFER_WRITE: phase_is_read = 1'b0;
      tscm_pkg::XFER_READ_WRITE: phase_is_read = !p2;
      tscm_pkg::XFER_WRITE_READ: phase_is_read = p2;
    endcase
  endfunction

  function automatic logic combined(tscm_pkg::tscm_xfer_e x);
    combined = (x == tscm_pkg::XFER_READ_WRITE) ||
               (x == tscm_pkg::XFER_WRITE_READ);
  endfunction

  assign phase_rd = phase_is_read(cmd.xfer, phase2);
  assign tick = (state != ST_IDLE) && (qcnt == '0);

  // Sampling pin input: three flops, level accepted when stages 2 and 3 agree
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_sync <= 3'h7;
      sda_s <= 1'b1;
    end else begin
      sda_sync <= {sda_sync[1:0], sda_i};
      if (sda_sync[2] == sda_sync[1]) begin
        sda_s <= sda_sync[2];
      end
    end
  end

  // Quarter-bit timer; rate reloads from the latched speed bit
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qcnt <= '0;
    end else if (state == ST_IDLE || qcnt == '0) begin
      qcnt <= cmd.fast ? tscm_pkg::QTR_W'(tscm_pkg::FAST_QTR - 1)
                       : tscm_pkg::QTR_W'(tscm_pkg::STD_QTR - 1);
    end else begin
      qcnt <= qcnt - 1'b1;
    end
  end

  // Main sequencer; there is no arbitration, the bus is assumed ours
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      cmd <= '0;
      phase2 <= 1'b0;
      quarter <= 2'h0;
      bitn <= 4'h0;
      shreg <= '0;
      left <= '0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      wr_take_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
      stat_o <= '0;
    end else begin
      wr_take_o <= 1'b0;
      rd_valid_o <= 1'b0;
      stat_o.done <= 1'b0;
      if (state == ST_IDLE) begin
        if (cmd_valid_i) begin
          cmd <= cmd_i;
          phase2 <= 1'b0;
          quarter <= 2'h0;
          stat_o.busy <= 1'b1;
          stat_o.nack <= 1'b0;
          state <= ST_START;
        end
      end else if (tick) begin
        quarter <= quarter + 1'b1;
        unique case (state)
          ST_START, ST_RESTART: begin
            // SDA falls while SCL is high, then SCL falls
            unique case (quarter)
              2'h0: begin
                sda_low <= 1'b0;
              end
              2'h1: begin
                scl_low <= 1'b0;
              end
              2'h2: begin
                sda_low <= 1'b1;
              end
              2'h3: begin
                scl_low <= 1'b1;
                shreg <= {cmd.addr, phase_rd, 1'b1};
                left <= phase2 ? cmd.len2 : cmd.len1;
                bitn <= 4'h0;
                state <= ST_ADDR;
              end
            endcase
          end
          ST_ADDR, ST_WBYTE, ST_RBYTE: begin
            unique case (quarter)
              2'h0: begin
                if (bitn < 4'h8) begin
                  sda_low <= (state == ST_RBYTE) ? 1'b0 : !shreg[8];
                end else begin
                  // Ack slot: master acks all but the last read byte
                  sda_low <= (state == ST_RBYTE) && (left != 1);
                end
              end
              2'h1: begin
                scl_low <= 1'b0;
              end
              2'h2: begin
                if (bitn < 4'h8) begin
                  // One shift a bit: top bit goes out, pin comes in below
                  shreg <= {shreg[7:0], sda_s};
                end else if (state != ST_RBYTE && sda_s) begin
                  stat_o.nack <= 1'b1;
                end
              end
              2'h3: begin
                scl_low <= 1'b1;
                bitn <= bitn + 1'b1;
                if (bitn == 4'h8) begin
                  bitn <= 4'h0;
                  if (state == ST_RBYTE) begin
                    rd_data_o <= shreg[7:0];
                    rd_valid_o <= 1'b1;
                    left <= left - 1'b1;
                  end else if (state == ST_WBYTE) begin
                    left <= left - 1'b1;
                  end
                  if (state != ST_RBYTE && stat_o.nack) begin
                    state <= ST_STOP;
                  end else if ((state == ST_ADDR && left == 0) ||
                      (state != ST_ADDR && left == 1)) begin
                    if (combined(cmd.xfer) && !phase2) begin
                      phase2 <= 1'b1;
                      state <= ST_RESTART;
                    end else begin
                      state <= ST_STOP;
                    end
                  end else if (phase_rd) begin
                    state <= ST_RBYTE;
                  end else begin
                    shreg <= {wr_data_i, 1'b1};
                    wr_take_o <= 1'b1;
                    state <= ST_WBYTE;
                  end
                end
              end
            endcase
          end
          ST_STOP: begin
            // SDA rises while SCL is high
            unique case (quarter)
              2'h0: begin
                sda_low <= 1'b1;
              end
              2'h1: begin
                scl_low <= 1'b0;
              end
              2'h2: begin
                sda_low <= 1'b0;
              end
              2'h3: begin
                stat_o.busy <= 1'b0;
                stat_o.done <= 1'b1;
                state <= ST_IDLE;
              end
            endcase
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Open drain: drive low only, released lines float high
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_o <= 1'b1;
      scl_oe_o <= 1'b0;
      sda_o <= 1'b1;
      sda_oe_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      scl_oe_o <= scl_low;
      sda_o <= 1'b0;
      sda_oe_o <= sda_low;
    end
  end

endmodule // tscm_master

// ==== hw/tscm_pkg.sv ====
// Package for the two-wire serial control master: command and status types,
// timing constants. Assumes a 100 MHz system clock.
package tscm_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned STD_HZ = 100_000;
  localparam int unsigned FAST_HZ = 400_000;
  // Quarter bit periods, rounded up so the bus never runs above the rate
  localparam int unsigned STD_QTR = (CLK_HZ + STD_HZ * 4 - 1) / (STD_HZ * 4);
  localparam int unsigned FAST_QTR =
      (CLK_HZ + FAST_HZ * 4 - 1) / (FAST_HZ * 4);
  localparam int unsigned QTR_W = 8;
  localparam int unsigned LEN_W = 4;

  typedef enum logic [1:0] {
    XFER_READ,
    XFER_WRITE,
    XFER_READ_WRITE,
    XFER_WRITE_READ
  } tscm_xfer_e;

  typedef struct packed {
    tscm_xfer_e xfer;
    logic fast;
    logic [6:0] addr;
    logic [LEN_W-1:0] len1;
    logic [LEN_W-1:0] len2;
  } tscm_cmd_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic nack;
  } tscm_stat_s;

endpackage

// ==== bench/tscm_master_chk.sv ====
// Port checker for the serial control master.
// Assumes ref_clk_i at 100 MHz and open-drain pins with pull-ups.
module tscm_master_chk (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire tscm_pkg::tscm_cmd_s cmd_i,
  input wire logic wr_take_o,
  input wire logic rd_valid_o,
  input wire tscm_pkg::tscm_stat_s stat_o,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] per;
  logic seen;
  logic fst;
  logic oe_q;
  wire rise = oe_q && !scl_oe_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Cycles between SCL releases; the first release of a transfer is skipped
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      per <= '0;
      seen <= 1'b0;
      fst <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= scl_oe_o;
      if (!stat_o.busy && cmd_valid_i) fst <= cmd_i.fast;
      seen <= stat_o.busy && (seen || rise);
      if (rise) per <= 12'h001;
      else if (per != 12'hfff) per <= per + 12'h001;
    end
  end
  property p_fast;
    stat_o.busy && seen && rise && fst |-> per >= 12'h0fa;
  endproperty
  a_fast: assert property (p_fast) else $error("fast rate too high");
  property p_std;
    stat_o.busy && seen && rise && !fst |-> per >= 12'h3e8;
  endproperty
  a_std: assert property (p_std) else $error("standard rate too high");
  property p_idle;
    !stat_o.busy && !$past(stat_o.busy) |-> !scl_oe_o && !sda_oe_o;
  endproperty
  a_idle: assert property (p_idle) else $error("bus driven when idle");
  property p_take;
    !stat_o.busy && cmd_valid_i |=> stat_o.busy;
  endproperty
  a_take: assert property (p_take) else $error("command not taken");
  property p_hold;
    !stat_o.busy && !cmd_valid_i |=> !stat_o.busy;
  endproperty
  a_hold: assert property (p_hold) else $error("started unasked");
  property p_low;
    stat_o.busy |-> !scl_o && !sda_o;
  endproperty
  a_low: assert property (p_low) else $error("pin driven high");
  property p_rd;
    rd_valid_o |-> stat_o.busy;
  endproperty
  a_rd: assert property (p_rd) else $error("read byte when idle");
  property p_wr;
    wr_take_o |-> stat_o.busy;
  endproperty
  a_wr: assert property (p_wr) else $error("write take when idle");
  c_done: cover property (stat_o.done);
  c_rd: cover property (rd_valid_o);
  c_nack: cover property (stat_o.nack && stat_o.done);
endmodule // tscm_master_chk

bind tscm_master tscm_master_chk u_chk (.*);

// ==== bench/tscm_slave.sv ====
// Behavioural slave on the two wires: acks, returns a fixed read byte.
// Assumes pull-ups; it only ever pulls SDA low and never touches SCL.
module tscm_slave (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic nak_i,
  output logic pull_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RD_BYTE = 8'hc3;
  logic [7:0] sh = '0;
  logic [7:0] last = '0;
  logic rd = 0;
  logic first = 0;
  int cnt = 0;
  int starts = 0;
  initial pull_o = 1'b0;
  always @(negedge sda_i) if (scl_i) begin
    starts++;
    cnt = 0;
    first = 1;
    rd = 0;
  end
  always @(posedge sda_i) if (scl_i) rd = 0;
  always @(posedge scl_i) begin
    if (cnt < 8) sh = {sh[6:0], sda_i};
    if (cnt == 8 && rd && sda_i) rd = 0;
    cnt = (cnt < 8) ? cnt + 1 : 0;
  end
  // SDA changes only while SCL is low; SCL is never held
  always @(negedge scl_i) begin
    if (cnt == 8 && !first && !rd) last = sh;
    if (cnt == 8) begin
      pull_o = (first || !rd) && !nak_i;
      if (first) rd = sh[0] && !nak_i;
      first = 0;
    end else pull_o = rd && !RD_BYTE[7 - cnt];
  end
endmodule // tscm_slave

// ==== bench/two_wire_serial_control_master_tb.sv ====
// Testbench: master against the slave model, wires resolved here.
// Assumes pull-ups on SCL and SDA.
module two_wire_serial_control_master_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, rst_n_i = 0, cmd_valid_i = 0, nak = 0;
  tscm_pkg::tscm_cmd_s cmd_i = '0;
  logic [7:0] wr_data_i = 8'h10;
  logic wr_take_o, rd_valid_o, scl_o, scl_oe_o, sda_o, sda_oe_o, pull;
  logic [7:0] rd_data_o;
  tscm_pkg::tscm_stat_s stat_o;
  int bad_count = 0, checks = 0;
  wire scl = !scl_oe_o;
  wire sda = !sda_oe_o && !pull;
  always #5 ref_clk_i = !ref_clk_i;
  tscm_master dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i),
    .wr_data_i(wr_data_i),
    .wr_take_o(wr_take_o),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .stat_o(stat_o),
    .scl_i(scl),
    .scl_o(scl_o),
    .scl_oe_o(scl_oe_o),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o)
  );
  tscm_slave sl (.scl_i(scl), .sda_i(sda), .nak_i(nak), .pull_o(pull));
  task automatic stop_test();
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic xfer(input logic [1:0] x, input logic f,
      input logic [3:0] a, b, input int ewr, erd, est, input logic enk);
    int n, wt, rv, s0;
    logic tk;
    n = 0; wt = 0; rv = 0; tk = 0; s0 = sl.starts;
    cmd_i = '{tscm_pkg::tscm_xfer_e'(x), f, 7'h2a, a, b};
    cmd_valid_i = 1'b1;
    @(posedge ref_clk_i) #1;
    cmd_valid_i = 1'b0;
    while (stat_o.done !== 1'b1 && n < 30000) begin
      @(posedge ref_clk_i) #1;
      n++;
      if (tk) wr_data_i++;
      tk = wr_take_o;
      wt += wr_take_o;
      rv += rd_valid_o;
      if (rd_valid_o) chk(rd_data_o === 8'hc3, "read byte");
    end
    chk(n < 30000, "no done");
    chk(wt == ewr && rv == erd, "byte counts");
    chk(sl.starts - s0 == est, "start count");
    chk(stat_o.nack === enk, "nack flag");
    if (ewr > 0) chk(sl.last === wr_data_i - 8'h01, "write byte");
  endtask
  task automatic t_idle();
    repeat (50) @(posedge ref_clk_i);
    #1 chk(sl.starts == 0 && stat_o.busy === 1'b0, "idle start");
  endtask
  task automatic t_read(); xfer(0, 1, 2, 0, 0, 2, 1, 0); endtask
  task automatic t_write(); xfer(1, 1, 2, 0, 2, 0, 1, 0); endtask
  task automatic t_rdwr(); xfer(2, 1, 1, 2, 2, 1, 2, 0); endtask
  task automatic t_wrrd(); xfer(3, 1, 2, 1, 2, 1, 2, 0); endtask
  task automatic t_std(); xfer(1, 0, 1, 0, 1, 0, 1, 0); endtask
  task automatic t_nak();
    nak = 1'b1;
    xfer(3, 1, 1, 1, 0, 0, 1, 1);
    nak = 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    t_idle();
    t_read();
    t_write();
    t_rdwr();
    t_wrrd();
    t_std();
    t_nak();
    stop_test();
  end
  initial begin
    #900000;
    bad_count++;
    stop_test();
  end
endmodule // two_wire_serial_control_master_tb
